// file: core/tdw_regs.v
// tile debug watchpoints and tile configuration registers
`timescale 1ns/1ps
`include "tdw_map.vh"
//
// Function
// [RULE_01] four first-address words at 0x50..0x53, writable in debug mode
// [RULE_02] four second-address words at 0x60..0x63, writable in debug mode
// [RULE_03] control bits 23:16 enable each thread, reset zero; gate firing
// [RULE_04] data control bit 2 adds loads to the trigger
// [RULE_05] data control bit 1: zero needs A and B, one needs A or B
// [RULE_06] control bit 0 enables the watchpoint; disabled never interrupts
// [RULE_07] data controls at 0x70..0x73; bits 31:24 and 15:3 read zero
// [RULE_08] resource masks at 0x80, resource values at 0x90
// [RULE_09] resource controls from 0x9c; bit 1 picks condition A or B
// [RULE_10] identification word at 0x00: id, node, revision, version
// [RULE_11] counts word at 0x01: channel ends, locks, synchronisers
// [RULE_12] counts word at 0x02: clock blocks and timers
// [RULE_13] lock bit 0 makes system switch writes read only
// [RULE_14] lock bit 31 refuses writes from switch, scratch path and test port
// [RULE_15] writing one to request bit 0 raises a debug interrupt
// [RULE_16] request bit 1 reads one while in debug mode
// [RULE_17] divider word bits 15:0 hold the clock divisor, reset zero
// [RULE_18] divisor acts only when the tile control enables it
// [RULE_19] divider bit 31 stops the tile clock, reset zero
// [RULE_20] eight core program counters readable at 0x40..0x47
// [RULE_21] eight core status words readable at 0x60..0x67
// [RULE_22] registers reached only by configuration read and write transactions
// [RULE_23] cause code 4 for data hit, 5 for resource hit
// [RULE_24] lowest numbered watchpoint wins on simultaneous hits
// [RULE_25] capture effective address or resource id on a hit
// [RULE_26] condition A compares first address, B second; stores always checked
// [RULE_27] resource condition compares masked id against value
module tdw_regs (
  // clock and reset
  input wire clk,
  input wire rst_n,
  // configuration transaction port
  input wire cfg_valid,
  input wire cfg_write,
  input wire cfg_debug_space,
  input wire [1:0] cfg_source,
  input wire [7:0] cfg_num,
  input wire [31:0] cfg_wdata,
  output reg cfg_ack_ff,
  output reg cfg_err_ff,
  output reg [31:0] cfg_rdata_ff,
  // processor state
  input wire in_debug_mode,
  input wire [255:0] core_pc_flat,
  input wire [255:0] core_sr_flat,
  input wire [31:0] security_word,
  input wire [7:0] node_number,
  // memory and resource activity
  input wire mem_valid,
  input wire mem_is_load,
  input wire [2:0] mem_thread,
  input wire [31:0] mem_addr,
  input wire res_valid,
  input wire [2:0] res_thread,
  input wire [31:0] res_id,
  // debug interrupt and clock control
  output reg dbg_irq_req_ff,
  output reg dbg_watch_hit_ff,
  output reg [2:0] dbg_cause_ff,
  output reg [1:0] dbg_watch_num_ff,
  output reg [7:0] dbg_thread_ff,
  output reg [31:0] dbg_data_ff,
  output reg [15:0] tile_div_ff,
  output reg tile_clk_stop_ff,
  input wire tile_div_enable
);
  parameter [7:0] PROC_ID = 8'h00;   // arbitrary value
  parameter [7:0] TILE_REV = 8'h01;  // arbitrary value
  parameter [7:0] TILE_VER = 8'h01;  // arbitrary value
  parameter [7:0] N_CHANEND = 8'h20;
  parameter [7:0] N_LOCK = 8'h04;
  parameter [7:0] N_SYNC = 8'h07;
  parameter [7:0] N_CLKBLK = 8'h06;
  parameter [7:0] N_TIMER = 8'h0a;

  reg [31:0] first_addr_ff [0:3];
  reg [31:0] second_addr_ff [0:3];
  reg [31:0] data_ctrl_ff [0:3];
  reg [31:0] res_mask_ff [0:3];
  reg [31:0] res_value_ff [0:3];
  reg [31:0] res_ctrl_ff [0:3];
  reg [31:0] scratch_ff [0:7];
  reg lock_sys_ff;
  reg lock_all_ff;
  reg [2:0] dbg_cause_reg_ff;
  reg [31:0] dbg_data_reg_ff;
  reg [1:0] dbg_num_reg_ff;
  reg [7:0] dbg_thr_reg_ff;
  reg [15:0] div_store_ff;

  reg [3:0] data_hit;
  reg [3:0] res_hit;
  reg cond_a;
  reg cond_b;
  reg [31:0] rd;
  reg rd_ok;
  reg [1:0] sel_data;
  reg [1:0] sel_res;
  integer i;

  wire [1:0] idx = cfg_num[1:0];
  wire [2:0] idx8 = cfg_num[2:0];
  // lock checks apply only to the configuration space; debug space needs debug mode
  wire cfg_wr_ok = ~lock_all_ff & ~(lock_sys_ff & (cfg_source == `TDW_SRC_SYSSW)); // [RULE_13] [RULE_14]
  wire dbg_wr_ok = in_debug_mode;
  wire cfg_wr = cfg_valid & cfg_write & ~cfg_debug_space & cfg_wr_ok;
  wire dbg_wr = cfg_valid & cfg_write & cfg_debug_space & dbg_wr_ok;
  wire div_wr = cfg_wr & (cfg_num == `TDW_CFG_CLK_DIV);

  // watchpoint match logic
  always @* begin
    data_hit = 4'h0;
    res_hit = 4'h0;
    cond_a = 1'b0;
    cond_b = 1'b0;
    for (i = 0; i < 4; i = i + 1) begin
      cond_a = (mem_addr == first_addr_ff[i]); // [RULE_26]
      cond_b = (mem_addr == second_addr_ff[i]);
      // stores always qualify, loads only with the load bit
      data_hit[i] = mem_valid & data_ctrl_ff[i][`TDW_CTRL_ENABLE] & // [RULE_06]
        data_ctrl_ff[i][`TDW_CTRL_THR_LO + mem_thread] & // [RULE_03]
        (~mem_is_load | data_ctrl_ff[i][`TDW_CTRL_LOADS]) & // [RULE_04]
        (data_ctrl_ff[i][`TDW_CTRL_COND] ? (cond_a | cond_b) : (cond_a & cond_b)); // [RULE_05]
      // condition A: masked id equals value; condition B: it differs
      cond_a = ((res_id & res_mask_ff[i]) == res_value_ff[i]); // [RULE_27]
      res_hit[i] = res_valid & res_ctrl_ff[i][`TDW_CTRL_ENABLE] & // [RULE_06]
        res_ctrl_ff[i][`TDW_CTRL_THR_LO + res_thread] & // [RULE_03]
        (res_ctrl_ff[i][`TDW_CTRL_COND] ? ~cond_a : cond_a); // [RULE_09]
    end
  end

  // lowest-numbered watchpoint wins
  always @* begin
    sel_data = 2'h0;
    sel_res = 2'h0;
    for (i = 3; i >= 0; i = i - 1) begin
      if (data_hit[i]) begin
        sel_data = i[1:0]; // [RULE_24]
      end
      if (res_hit[i]) begin
        sel_res = i[1:0];
      end
    end
  end

  // read decode
  always @* begin
    rd = `TDW_RST_WORD;
    rd_ok = 1'b1;
    if (cfg_debug_space) begin
      case (cfg_num[7:2])
        6'h14: rd = first_addr_ff[idx]; // [RULE_01]
        6'h18: rd = second_addr_ff[idx]; // [RULE_02]
        6'h1c: rd = {8'h00, data_ctrl_ff[idx][23:16], 13'h0000, data_ctrl_ff[idx][2:0]}; // [RULE_07]
        6'h20: rd = res_mask_ff[idx]; // [RULE_08]
        6'h24: rd = res_value_ff[idx];
        6'h27: rd = {8'h00, res_ctrl_ff[idx][23:16], 14'h0000, res_ctrl_ff[idx][1:0]};
        default: begin
          if (cfg_num == `TDW_DBG_INT_TYPE) begin
            rd = {14'h0000, dbg_num_reg_ff, dbg_thr_reg_ff, 5'h00, dbg_cause_reg_ff};
          end else if (cfg_num == `TDW_DBG_INT_DATA) begin
            rd = dbg_data_reg_ff;
          end else if (cfg_num[7:3] == 5'h04) begin
            rd = scratch_ff[idx8];
          end else begin
            rd_ok = 1'b0;
          end
        end
      endcase
    end else begin
      case (cfg_num)
        `TDW_CFG_IDENT: rd = {PROC_ID, node_number, TILE_REV, TILE_VER}; // [RULE_10]
        `TDW_CFG_COUNTS_ONE: rd = {N_CHANEND, N_LOCK, N_SYNC, 8'h00}; // [RULE_11]
        `TDW_CFG_COUNTS_TWO: rd = {16'h0000, N_CLKBLK, N_TIMER}; // [RULE_12]
        `TDW_CFG_LOCK: rd = {lock_all_ff, 30'h00000000, lock_sys_ff};
        `TDW_CFG_DBG_REQ: rd = {30'h00000000, in_debug_mode, dbg_irq_req_ff}; // [RULE_16]
        `TDW_CFG_CLK_DIV: rd = {tile_clk_stop_ff, 15'h0000, div_store_ff}; // [RULE_17]
        `TDW_CFG_SECURITY: rd = security_word;
        default: begin
          if (cfg_num[7:3] == 5'h04) begin
            rd = scratch_ff[idx8];
          end else if (cfg_num[7:3] == 5'h08) begin
            rd = core_pc_flat[{idx8, 5'h00} +: 32]; // [RULE_20]
          end else if (cfg_num[7:3] == 5'h0c) begin
            rd = core_sr_flat[{idx8, 5'h00} +: 32]; // [RULE_21]
          end else begin
            rd_ok = 1'b0;
          end
        end
      endcase
    end
  end

  // configuration transaction answer, one cycle after the request
  always @(posedge clk) begin
    if (!rst_n) begin
      cfg_ack_ff <= 1'b0;
      cfg_err_ff <= 1'b0;
      cfg_rdata_ff <= `TDW_RST_WORD;
    end else begin
      cfg_ack_ff <= cfg_valid; // [RULE_22]
      // refused writes and unmapped numbers are flagged, not silently absorbed
      cfg_err_ff <= cfg_valid & (~rd_ok | (cfg_write & (cfg_debug_space ? ~dbg_wr_ok : ~cfg_wr_ok)));
      cfg_rdata_ff <= (cfg_valid & ~cfg_write & rd_ok) ? rd : `TDW_RST_WORD;
    end
  end

  // watchpoint register writes (debug space)
  always @(posedge clk) begin
    if (!rst_n) begin
      for (i = 0; i < 4; i = i + 1) begin
        first_addr_ff[i] <= `TDW_RST_WORD;
        second_addr_ff[i] <= `TDW_RST_WORD;
        data_ctrl_ff[i] <= `TDW_RST_WORD; // [RULE_03]
        res_mask_ff[i] <= `TDW_RST_WORD;
        res_value_ff[i] <= `TDW_RST_WORD;
        res_ctrl_ff[i] <= `TDW_RST_WORD;
      end
    end else if (dbg_wr) begin
      case (cfg_num[7:2])
        6'h14: first_addr_ff[idx] <= cfg_wdata; // [RULE_01]
        6'h18: second_addr_ff[idx] <= cfg_wdata; // [RULE_02]
        6'h1c: data_ctrl_ff[idx] <= cfg_wdata & 32'h00ff_0007; // [RULE_07]
        6'h20: res_mask_ff[idx] <= cfg_wdata; // [RULE_08]
        6'h24: res_value_ff[idx] <= cfg_wdata;
        6'h27: res_ctrl_ff[idx] <= cfg_wdata & 32'h00ff_0003; // [RULE_09]
        default: ;
      endcase
    end
  end

  // scratch words shared by both spaces
  always @(posedge clk) begin
    if (!rst_n) begin
      for (i = 0; i < 8; i = i + 1) begin
        scratch_ff[i] <= `TDW_RST_WORD;
      end
    end else if ((cfg_wr | dbg_wr) && cfg_num[7:3] == 5'h04) begin
      scratch_ff[idx8] <= cfg_wdata;
    end
  end

  // tile configuration writes
  always @(posedge clk) begin
    if (!rst_n) begin
      lock_sys_ff <= 1'b0;
      lock_all_ff <= 1'b0;
      div_store_ff <= `TDW_RST_DIV; // [RULE_17]
      tile_clk_stop_ff <= 1'b0; // [RULE_19]
    end else if (cfg_wr) begin
      if (cfg_num == `TDW_CFG_LOCK) begin
        lock_sys_ff <= cfg_wdata[`TDW_LOCK_SYS]; // [RULE_13]
        lock_all_ff <= cfg_wdata[`TDW_LOCK_ALL]; // [RULE_14]
      end
      if (cfg_num == `TDW_CFG_CLK_DIV) begin
        // divisor is stored always, applied downstream only with tile_div_enable
        div_store_ff <= cfg_wdata[15:0]; // [RULE_17]
        tile_clk_stop_ff <= cfg_wdata[`TDW_DIV_STOP]; // [RULE_19]
      end
    end
  end

  // divisor handed to the clock generator only while enabled; held otherwise
  always @(posedge clk) begin
    if (!rst_n) begin
      tile_div_ff <= `TDW_RST_DIV;
    end else if (tile_div_enable) begin
      tile_div_ff <= div_wr ? cfg_wdata[15:0] : div_store_ff; // [RULE_18]
    end
  end

  // interrupt data copy for the debugger side
  always @(posedge clk) begin
    if (!rst_n) begin
      dbg_data_ff <= `TDW_RST_WORD;
    end else begin
      dbg_data_ff <= dbg_data_reg_ff;
    end
  end

  // debug interrupt request and watchpoint capture; request write wins over the debug-mode clear
  always @(posedge clk) begin
    if (!rst_n) begin
      dbg_irq_req_ff <= 1'b0;
      dbg_watch_hit_ff <= 1'b0;
      dbg_cause_reg_ff <= 3'h0;
      dbg_data_reg_ff <= `TDW_RST_WORD;
      dbg_num_reg_ff <= 2'h0;
      dbg_thr_reg_ff <= 8'h00;
      dbg_cause_ff <= 3'h0;
      dbg_watch_num_ff <= 2'h0;
      dbg_thread_ff <= 8'h00;
    end else begin
      dbg_watch_hit_ff <= (|data_hit | |res_hit) & ~in_debug_mode;
      if (cfg_wr && cfg_num == `TDW_CFG_DBG_REQ) begin
        dbg_irq_req_ff <= cfg_wdata[`TDW_REQ_IRQ]; // [RULE_15]
      end else if (in_debug_mode) begin
        dbg_irq_req_ff <= 1'b0;
      end
      // no new capture while already in debug mode, to keep the first cause
      if (~in_debug_mode && |data_hit) begin
        dbg_cause_reg_ff <= `TDW_CAUSE_DATA; // [RULE_23]
        dbg_num_reg_ff <= sel_data; // [RULE_24]
        dbg_thr_reg_ff <= {5'h00, mem_thread};
        dbg_data_reg_ff <= mem_addr; // [RULE_25]
      end else if (~in_debug_mode && |res_hit) begin
        dbg_cause_reg_ff <= `TDW_CAUSE_RES; // [RULE_23]
        dbg_num_reg_ff <= sel_res;
        dbg_thr_reg_ff <= {5'h00, res_thread};
        dbg_data_reg_ff <= res_id; // [RULE_25]
      end else if (dbg_wr && cfg_num == `TDW_DBG_INT_TYPE) begin
        dbg_cause_reg_ff <= cfg_wdata[2:0];
        dbg_thr_reg_ff <= cfg_wdata[15:8];
        dbg_num_reg_ff <= cfg_wdata[17:16];
      end else if (dbg_wr && cfg_num == `TDW_DBG_INT_DATA) begin
        dbg_data_reg_ff <= cfg_wdata;
      end
      dbg_cause_ff <= dbg_cause_reg_ff;
      dbg_watch_num_ff <= dbg_num_reg_ff;
      dbg_thread_ff <= dbg_thr_reg_ff;
    end
  end

endmodule

// file: core/tdw_map.vh
// register offsets, field positions and reset values of the tile debug watchpoint block
`ifndef TDW_MAP_VH
`define TDW_MAP_VH
// debug-mode register space (8-bit register numbers)
`define TDW_DBG_FIRST_ADDR 8'h50
`define TDW_DBG_SECOND_ADDR 8'h60
`define TDW_DBG_DATA_CTRL 8'h70
`define TDW_DBG_RES_MASK 8'h80
`define TDW_DBG_RES_VALUE 8'h90
`define TDW_DBG_RES_CTRL 8'h9c
`define TDW_DBG_INT_TYPE 8'h15
`define TDW_DBG_INT_DATA 8'h16
// tile configuration space
`define TDW_CFG_IDENT 8'h00
`define TDW_CFG_COUNTS_ONE 8'h01
`define TDW_CFG_COUNTS_TWO 8'h02
`define TDW_CFG_LOCK 8'h04
`define TDW_CFG_DBG_REQ 8'h05
`define TDW_CFG_CLK_DIV 8'h06
`define TDW_CFG_SECURITY 8'h07
`define TDW_CFG_SCRATCH 8'h20
`define TDW_CFG_CORE_PC 8'h40
`define TDW_CFG_CORE_SR 8'h60
// control field positions
`define TDW_CTRL_ENABLE 0
`define TDW_CTRL_COND 1
`define TDW_CTRL_LOADS 2
`define TDW_CTRL_THR_LO 16
`define TDW_CTRL_THR_HI 23
`define TDW_LOCK_SYS 0
`define TDW_LOCK_ALL 31
`define TDW_REQ_IRQ 0
`define TDW_REQ_DBGMODE 1
`define TDW_DIV_STOP 31
// reset values and cause codes
`define TDW_RST_WORD 32'h0000_0000
`define TDW_RST_DIV 16'h0000
`define TDW_CAUSE_DATA 3'h4
`define TDW_CAUSE_RES 3'h5
// access sources
`define TDW_SRC_SYSSW 2'h0
`define TDW_SRC_SCRATCH 2'h1
`define TDW_SRC_TEST 2'h2
`define TDW_SRC_DEBUG 2'h3
`endif

// file: dv/tdw_regs_monitor.sv
// assertion checker watching the ports of the tile debug watchpoint register block
`timescale 1ns/1ps
module tdw_regs_monitor (
  // clock and reset
  input wire clk,
  input wire rst_n,
  // configuration port
  input wire cfg_valid,
  input wire cfg_write,
  input wire cfg_debug_space,
  input wire [7:0] cfg_num,
  input wire cfg_ack_ff,
  input wire cfg_err_ff,
  input wire [31:0] cfg_rdata_ff,
  // processor state and watch activity
  input wire in_debug_mode,
  input wire [255:0] core_pc_flat,
  input wire [7:0] node_number,
  input wire mem_valid,
  input wire res_valid,
  input wire dbg_watch_hit_ff,
  input wire [2:0] dbg_cause_ff
);
  default clocking dc @(posedge clk); endclocking
  default disable iff (!rst_n);
  // read requests decoded per space
  wire rd_cfg = cfg_valid && !cfg_write && !cfg_debug_space;
  wire rd_dbg = cfg_valid && !cfg_write && cfg_debug_space;
  chk_ack_next: assert property (cfg_valid |=> cfg_ack_ff)
    else $error("no ack after request");
  chk_ack_cause: assert property (cfg_ack_ff |-> $past(cfg_valid))
    else $error("ack without request");
  chk_rdata_idle: assert property (!cfg_ack_ff |-> cfg_rdata_ff == 32'h0)
    else $error("read data outside ack");
  chk_dbg_refuse: assert property (cfg_valid && cfg_write && cfg_debug_space && !in_debug_mode |=> cfg_err_ff)
    else $error("debug write outside debug mode taken");
  chk_ident_node: assert property (rd_cfg && cfg_num == 8'h00 |=> cfg_rdata_ff[23:16] == $past(node_number))
    else $error("node number wrong");
  chk_ctrl_reserved: assert property (rd_dbg && cfg_num[7:2] == 6'h1c |=> cfg_rdata_ff[31:24] == 8'h00 && cfg_rdata_ff[15:3] == 13'h0)
    else $error("reserved control bits set");
  chk_counts_two: assert property (rd_cfg && cfg_num == 8'h02 |=> cfg_rdata_ff[31:16] == 16'h0)
    else $error("counts word upper half set");
  chk_dbgmode_bit: assert property (rd_cfg && cfg_num == 8'h05 |=> cfg_rdata_ff[1] == $past(in_debug_mode))
    else $error("debug mode bit wrong");
  chk_pc_word: assert property (rd_cfg && cfg_num[7:3] == 5'h08 |=> cfg_rdata_ff == $past(core_pc_flat[{cfg_num[2:0], 5'h00} +: 32]))
    else $error("program counter word wrong");
  chk_quiet_debug: assert property (in_debug_mode |=> !dbg_watch_hit_ff)
    else $error("hit while in debug mode");
  chk_cause_data: assert property (dbg_watch_hit_ff && !$past(res_valid) |=> dbg_cause_ff == 3'h4)
    else $error("data cause code wrong");
  chk_cause_res: assert property (dbg_watch_hit_ff && !$past(mem_valid) |=> dbg_cause_ff == 3'h5)
    else $error("resource cause code wrong");
  // main scenarios reached
  cover property (rd_dbg);
  cover property (dbg_watch_hit_ff);
  cover property (cfg_err_ff);
endmodule

// file: dv/tdw_host.sv
// configuration access host standing at the far side of the register block
`timescale 1ns/1ps
module tdw_host (
  // clock
  input wire clk,
  // request
  output reg cfg_valid,
  output reg cfg_write,
  output reg cfg_debug_space,
  output reg [1:0] cfg_source,
  output reg [7:0] cfg_num,
  output reg [31:0] cfg_wdata,
  // answer
  input wire cfg_ack_ff,
  input wire cfg_err_ff,
  input wire [31:0] cfg_rdata_ff
);
  // idle request lines at time zero
  initial begin
    {cfg_valid, cfg_write, cfg_debug_space, cfg_source} = 5'h00;
    {cfg_num, cfg_wdata} = 40'h0;
  end
  // one configuration transaction; valid is a one-cycle pulse by contract
  task xfer(input w, input d, input [1:0] s, input [7:0] n, input [31:0] wd,
    output [31:0] rd, output e, output ok);
    integer k;
    begin
      cfg_valid <= 1'h1;
      cfg_write <= w;
      cfg_debug_space <= d;
      cfg_source <= s;
      cfg_num <= n;
      cfg_wdata <= wd;
      @(posedge clk);
      cfg_valid <= 1'h0;
      // released lines show no stale value
      cfg_num <= ~n;
      cfg_wdata <= ~wd;
      ok = 1'h0;
      for (k = 0; k < 4 && !ok; k = k + 1) begin
        @(posedge clk);
        ok = (cfg_ack_ff === 1'h1);
        rd = cfg_rdata_ff;
        e = cfg_err_ff;
      end
    end
  endtask
endmodule

// file: dv/tb_tile_debug_watchpoint_config_regs.sv
// self-checking bench for the tile debug watchpoint register block
`timescale 1ns/1ps
module tb_tile_debug_watchpoint_config_regs;
  localparam [0:0] RD = 1'h0, WR = 1'h1, CF = 1'h0, DB = 1'h1;
  localparam [7:0] PID = 8'h3c; // arbitrary value
  // stimulus and answers
  reg clk, rst_n, in_debug_mode, mem_valid, mem_is_load, res_valid, tile_div_enable, e, ok;
  reg [2:0] mem_thread, res_thread;
  reg [7:0] node_number;
  reg [31:0] mem_addr, res_id, security_word, rd;
  reg [255:0] core_pc_flat, core_sr_flat;
  wire cfg_valid, cfg_write, cfg_debug_space, cfg_ack_ff, cfg_err_ff;
  wire dbg_irq_req_ff, dbg_watch_hit_ff, tile_clk_stop_ff;
  wire [1:0] cfg_source, dbg_watch_num_ff;
  wire [2:0] dbg_cause_ff;
  wire [7:0] cfg_num, dbg_thread_ff;
  wire [15:0] tile_div_ff;
  wire [31:0] cfg_wdata, cfg_rdata_ff, dbg_data_ff;
  integer err_count, checked, cycles, i, j;
  tdw_regs #(.PROC_ID(PID), .TILE_REV(8'h02), .TILE_VER(8'h05)) DUT (.clk, .rst_n, .cfg_valid, .cfg_write,
    .cfg_debug_space, .cfg_source, .cfg_num, .cfg_wdata, .cfg_ack_ff, .cfg_err_ff, .cfg_rdata_ff,
    .in_debug_mode, .core_pc_flat, .core_sr_flat, .security_word, .node_number, .mem_valid, .mem_is_load,
    .mem_thread, .mem_addr, .res_valid, .res_thread, .res_id, .dbg_irq_req_ff, .dbg_watch_hit_ff,
    .dbg_cause_ff, .dbg_watch_num_ff, .dbg_thread_ff, .dbg_data_ff, .tile_div_ff, .tile_clk_stop_ff,
    .tile_div_enable);
  tdw_host host (.clk, .cfg_valid, .cfg_write, .cfg_debug_space, .cfg_source, .cfg_num, .cfg_wdata,
    .cfg_ack_ff, .cfg_err_ff, .cfg_rdata_ff);
  // 50 MHz clock
  initial begin
    clk = 1'h0;
    forever #10 clk = ~clk;
  end
  // hang guard, far above the few hundred cycles the run needs
  always @(posedge clk) begin
    cycles = cycles + 1;
    if (cycles == 4000) begin
      err_count = err_count + 1;
      give_verdict;
    end
  end
  task give_verdict;
    begin
      if (err_count == 0 && checked > 0)
        $display("NO MISMATCHES");
      else
        $display("MISMATCHES SEEN");
      $finish;
    end
  endtask
  task chk(input [47:0] seen, input [47:0] exp);
    begin
      checked = checked + 1;
      if (seen !== exp) begin
        err_count = err_count + 1;
        $display("Error at %0t: seen %h expected %h", $time, seen, exp);
      end
    end
  endtask
  task cf(input w, input d, input [1:0] s, input [7:0] n, input [31:0] wd);
    begin
      host.xfer(w, d, s, n, wd, rd, e, ok);
      chk(ok, 1'h1);
    end
  endtask
  // one memory or resource access outside debug mode, then hit and capture checks
  task act(input r, input ld, input [2:0] t, input [31:0] a, input h, input [2:0] c, input [1:0] n);
    begin
      in_debug_mode <= 1'h0;
      @(posedge clk);
      {mem_valid, res_valid, mem_is_load} <= {!r, r, ld};
      {mem_thread, res_thread, mem_addr, res_id} <= {t, t, a, a};
      @(posedge clk);
      {mem_valid, res_valid} <= 2'h0;
      @(posedge clk);
      chk(dbg_watch_hit_ff, h);
      @(posedge clk);
      if (h) chk({dbg_cause_ff, dbg_watch_num_ff, dbg_thread_ff, dbg_data_ff}, {c, n, 5'h00, t, a});
      in_debug_mode <= 1'h1;
    end
  endtask
  task t_reset;
    begin
      for (i = 4; i < 7; i = i + 1) begin
        cf(RD, CF, 2'h2, i[7:0], 32'h0);
        chk(rd, 32'h0);
      end
      cf(RD, DB, 2'h3, 8'h70, 32'h0);
      chk(rd, 32'h0);
      cf(RD, CF, 2'h2, 8'h03, 32'h0);
      chk({e, rd}, {1'h1, 32'h0});
    end
  endtask
  task t_ident;
    begin
      cf(RD, CF, 2'h2, 8'h00, 32'h0);
      chk(rd, {PID, node_number, 8'h02, 8'h05});
      cf(RD, CF, 2'h2, 8'h01, 32'h0);
      chk(rd, 32'h2004_0700);
      cf(RD, CF, 2'h2, 8'h02, 32'h0);
      chk(rd, 32'h0000_060a);
      for (i = 0; i < 8; i = i + 1) begin
        cf(RD, CF, 2'h0, 8'h40 + i[7:0], 32'h0);
        chk(rd, core_pc_flat[i*32 +: 32]);
        cf(RD, CF, 2'h0, 8'h60 + i[7:0], 32'h0);
        chk(rd, core_sr_flat[i*32 +: 32]);
      end
    end
  endtask
  task t_regs;
    begin
      in_debug_mode <= 1'h1;
      for (i = 0; i < 4; i = i + 1) begin
        for (j = 0; j < 4; j = j + 1) begin
          cf(WR, DB, 2'h3, 8'h50 + 16*j + (j > 1 ? 16 : 0) + i, 32'ha5a5_0000 + 16*j + i);
          cf(RD, DB, 2'h3, 8'h50 + 16*j + (j > 1 ? 16 : 0) + i, 32'h0);
          chk(rd, 32'ha5a5_0000 + 16*j + i);
        end
        cf(WR, DB, 2'h3, 8'h70 + i[7:0], 32'hffff_ffff);
        cf(RD, DB, 2'h3, 8'h70 + i[7:0], 32'h0);
        chk(rd, 32'h00ff_0007);
        cf(WR, DB, 2'h3, 8'h9c + i[7:0], 32'hffff_ffff);
        cf(RD, DB, 2'h3, 8'h9c + i[7:0], 32'h0);
        chk(rd, 32'h00ff_0003);
      end
      in_debug_mode <= 1'h0;
      cf(WR, DB, 2'h3, 8'h50, 32'h0);
      chk(e, 1'h1);
      cf(RD, DB, 2'h3, 8'h50, 32'h0);
      chk({e, rd}, {1'h0, 32'ha5a5_0000});
      in_debug_mode <= 1'h1;
    end
  endtask
  task t_watch;
    begin
      for (i = 0; i < 4; i = i + 1) begin
        cf(WR, DB, 2'h3, 8'h50 + i[7:0], 32'h1000);
        cf(WR, DB, 2'h3, 8'h70 + i[7:0], (i == 1 || i == 2) ? 32'h0004_0003 : 32'h0);
        cf(WR, DB, 2'h3, 8'h9c + i[7:0], 32'h0);
      end
      act(1'h0, 1'h0, 3'h2, 32'h1000, 1'h1, 3'h4, 2'h1);
      act(1'h0, 1'h1, 3'h2, 32'h1000, 1'h0, 3'h4, 2'h1);
      act(1'h0, 1'h0, 3'h3, 32'h1000, 1'h0, 3'h4, 2'h1);
      cf(WR, DB, 2'h3, 8'h71, 32'h0004_0007);
      act(1'h0, 1'h1, 3'h2, 32'h1000, 1'h1, 3'h4, 2'h1);
      cf(WR, DB, 2'h3, 8'h71, 32'h0004_0005);
      cf(WR, DB, 2'h3, 8'h72, 32'h0);
      act(1'h0, 1'h0, 3'h2, 32'h1000, 1'h0, 3'h4, 2'h1);
      cf(WR, DB, 2'h3, 8'h61, 32'h1000);
      act(1'h0, 1'h0, 3'h2, 32'h1000, 1'h1, 3'h4, 2'h1);
      cf(WR, DB, 2'h3, 8'h71, 32'h0004_0004);
      act(1'h0, 1'h0, 3'h2, 32'h1000, 1'h0, 3'h4, 2'h1);
      // resource watchpoint 0: masked id against value
      cf(WR, DB, 2'h3, 8'h80, 32'hffff_0000);
      cf(WR, DB, 2'h3, 8'h90, 32'h1234_0000);
      cf(WR, DB, 2'h3, 8'h9c, 32'h0002_0001);
      act(1'h1, 1'h0, 3'h1, 32'h1234_abcd, 1'h1, 3'h5, 2'h0);
      cf(WR, DB, 2'h3, 8'h9c, 32'h0002_0003);
      act(1'h1, 1'h0, 3'h1, 32'h1234_abcd, 1'h0, 3'h5, 2'h0);
      act(1'h1, 1'h0, 3'h1, 32'h1235_abcd, 1'h1, 3'h5, 2'h0);
    end
  endtask
  task t_lock;
    begin
      cf(WR, CF, 2'h0, 8'h06, 32'h8000_0123);
      chk({tile_clk_stop_ff, tile_div_ff}, {1'h1, 16'h0123});
      tile_div_enable <= 1'h0;
      cf(WR, CF, 2'h0, 8'h06, 32'h8000_0456);
      chk(tile_div_ff, 16'h0123);
      cf(RD, CF, 2'h0, 8'h06, 32'h0);
      chk(rd, 32'h8000_0456);
      tile_div_enable <= 1'h1;
      cf(WR, CF, 2'h0, 8'h06, 32'h8000_0123);
      chk(tile_div_ff, 16'h0123);
      in_debug_mode <= 1'h0;
      cf(WR, CF, 2'h0, 8'h05, 32'h1);
      chk(dbg_irq_req_ff, 1'h1);
      in_debug_mode <= 1'h1;
      cf(RD, CF, 2'h0, 8'h05, 32'h0);
      chk(rd[1], 1'h1);
      cf(WR, CF, 2'h0, 8'h04, 32'h1);
      cf(WR, CF, 2'h0, 8'h06, 32'h7);
      chk({e, tile_div_ff}, {1'h1, 16'h0123});
      cf(WR, CF, 2'h2, 8'h06, 32'h7);
      chk({e, tile_clk_stop_ff, tile_div_ff}, {2'h0, 16'h0007});
      cf(WR, CF, 2'h2, 8'h04, 32'h8000_0001);
      cf(WR, CF, 2'h1, 8'h06, 32'h9);
      chk({e, tile_div_ff}, {1'h1, 16'h0007});
      cf(RD, CF, 2'h1, 8'h06, 32'h0);
      chk({e, rd}, {1'h0, 32'h7});
    end
  endtask
  // reset, then scenarios in order; the lock goes last since it sticks until reset
  initial begin
    {err_count, checked, cycles} = 0;
    {rst_n, in_debug_mode, mem_valid, mem_is_load, res_valid, tile_div_enable} = 6'h01;
    {mem_thread, res_thread, mem_addr, res_id} = 70'h0;
    {node_number, security_word} = {8'h5a, 32'h0000_4011};
    for (i = 0; i < 8; i = i + 1)
      {core_pc_flat[i*32 +: 32], core_sr_flat[i*32 +: 32]} = {32'h1100_0000 * (i + 1), 32'h0000_0a50 + i};
    repeat (8) @(posedge clk);
    rst_n <= 1'h1;
    @(posedge clk);
    t_reset;
    t_ident;
    t_regs;
    t_watch;
    t_lock;
    give_verdict;
  end
endmodule
bind tdw_regs tdw_regs_monitor mon (.clk, .rst_n, .cfg_valid, .cfg_write, .cfg_debug_space, .cfg_num,
  .cfg_ack_ff, .cfg_err_ff, .cfg_rdata_ff, .in_debug_mode, .core_pc_flat, .node_number, .mem_valid,
  .res_valid, .dbg_watch_hit_ff, .dbg_cause_ff);
